// ==== design/uart_hold_defs.svh ====
// constants for the uart holding, mask and status block
// assumes inclusion by bare name from the receive front end and holding modules
`ifndef UART_HOLD_DEFS_SVH
`define UART_HOLD_DEFS_SVH
`define ADDR_HOLDING       3'h0
`define ADDR_MASK          3'h1
`define ADDR_IDENT_FIFO    3'h2
`define ADDR_LINE_CONTROL  3'h3
`define ADDR_LINE_STATUS   3'h5
`define MASK_RESET         8'h00
`define LCR_RESET          8'h00
`define LSR_RESET          8'h60
`define IDENT_NONE         4'h1
`define IDENT_RX_LINE      4'h6
`define IDENT_RX_DATA      4'h4
`define IDENT_TX_EMPTY     4'h2
`define IDENT_MODEM        4'h0
`define IDENT_XOFF         4'h0
`define IDENT_FLOW         4'h0
`define BIT_DLAB           7
`define BIT_FIFO_EN        0
`define FIFO_DEPTH         32
`define START_MID_COUNT    4'h7
`define BIT_SAMPLES        4'hF
`endif

// ==== design/uart_hold_pkg.sv ====
// types shared by the uart holding block
// assumes the defs header is on the include path
package uart_hold_pkg;
    typedef enum logic [1:0] {
        rx_idle  = 2'b00,
        rx_start = 2'b01,
        rx_data  = 2'b10,
        rx_stop  = 2'b11
    } rx_state_t;
    typedef logic [7:0] byte_t;
endpackage : uart_hold_pkg

// ==== design/uart_rx_front.sv ====
// receive front end: pin synchroniser, false start filter, assembly
// assumes a 16x sample tick from the same clock domain
`include "uart_hold_defs.svh"
module uart_rx_front
    import uart_hold_pkg::*;
(
    input  wire logic           clock,
    input  wire logic           srst,
    input  wire logic           tick16,
    input  wire logic           rx_pin,
    output uart_hold_pkg::byte_t rx_byte,
    output logic                rx_done,
    output logic                rx_frame_err,
    output logic                rx_break
);
    logic [2:0]  sync;
    logic        line;
    rx_state_t   state;
    logic [3:0]  count;
    logic [2:0]  bit_index;
    byte_t       shift;

    ////////////////////////////////////////////////////////////////////
    // three stage synchroniser; level moves once stages two and three agree
    always_ff @(posedge clock) begin
        if (srst) begin
            sync <= 3'h7;
            line <= 1'b1;
        end else begin
            sync <= {sync[1:0], rx_pin};
            if (sync[1] == sync[2])
                line <= sync[2];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assembly; mid start sample on the eighth tick, at count seven
    always_ff @(posedge clock) begin
        if (srst) begin
            state        <= rx_idle;
            count        <= 4'h0;
            bit_index    <= 3'h0;
            shift        <= 8'h00;
            rx_byte      <= 8'h00;
            rx_done      <= 1'b0;
            rx_frame_err <= 1'b0;
            rx_break     <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            unique case (state)
                rx_idle: begin
                    count <= 4'h0;
                    if (!line)
                        state <= rx_start;
                end
                rx_start: if (tick16) begin
                    count <= count + 4'h1;
                    if (count == `START_MID_COUNT) begin
                        // a glitch shorter than half a bit is dropped here
                        state     <= line ? rx_idle : rx_data;
                        count     <= 4'h0;
                        bit_index <= 3'h0;
                    end
                end
                rx_data: if (tick16) begin
                    count <= count + 4'h1;
                    if (count == `BIT_SAMPLES) begin
                        shift <= {line, shift[7:1]};
                        bit_index <= bit_index + 3'h1;
                        if (bit_index == 3'h7)
                            state <= rx_stop;
                    end
                end
                rx_stop: if (tick16) begin
                    count <= count + 4'h1;
                    if (count == `BIT_SAMPLES) begin
                        rx_byte      <= shift;
                        rx_done      <= 1'b1;
                        rx_frame_err <= !line;
                        rx_break     <= !line && (shift == 8'h00);
                        state        <= rx_idle;
                    end
                end
            endcase
        end
    end
endmodule : uart_rx_front

// ==== design/uart_hold.sv ====
// uart holding registers, interrupt mask, line status and interrupt
// assumes host strobes one cycle wide, synchronous to clock
`include "uart_hold_defs.svh"
module uart_hold
    import uart_hold_pkg::*;
#(
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int AW    = $clog2(`FIFO_DEPTH)
) (
    input  wire logic            clock,
    input  wire logic            srst,
    input  wire logic [2:0]      addr,
    input  wire logic            wr_strobe,
    input  wire logic            rd_strobe,
    input  wire uart_hold_pkg::byte_t wr_data,
    output uart_hold_pkg::byte_t rd_data,
    input  wire logic            tick16,
    input  wire logic            rx_pin,
    output logic                 tx_pin,
    input  wire logic            cts_pin,
    input  wire logic            rts_level,
    input  wire logic            modem_event,
    input  wire logic            xoff_seen,
    output logic                 irq,
    output logic                 sleep_mode
);
    import uart_hold_pkg::*;

    // host visible control state
    byte_t          mask;
    byte_t          line_control;
    logic           fifo_en;
    logic [1:0]     rx_trig_sel;
    logic           dlab;
    // receive storage, one error tag per byte
    byte_t          rx_mem [DEPTH];
    logic [3:0]     err_mem [DEPTH];
    logic [AW-1:0]  rx_wp;
    logic [AW-1:0]  rx_rp;
    logic [AW:0]    rx_cnt;
    // transmit storage and serialiser
    byte_t          tx_mem [DEPTH];
    logic [AW-1:0]  tx_wp;
    logic [AW-1:0]  tx_rp;
    logic [AW:0]    tx_cnt;
    byte_t          tx_shift;
    logic [3:0]     tx_count;
    logic [3:0]     tx_bits;
    logic           tx_busy;
    // handshake from the receive front end
    byte_t          rx_byte;
    logic           rx_done;
    logic           rx_frame_err;
    logic           rx_break;
    logic           overrun;
    // modem edges and sticky event flags
    logic [2:0]     cts_sync;
    logic           cts_line;
    logic           cts_prev;
    logic           rts_prev;
    logic           cts_flag;
    logic           rts_flag;
    logic           line_flag;
    logic [5:0]     err_total;
    // decode and level helpers
    logic           wr_hold;
    logic           rd_hold;
    logic           tx_take;
    logic           rx_push;
    logic [AW:0]    rx_limit;
    logic [AW:0]    tx_limit;
    logic [AW:0]    trig_level;
    logic           thr_empty;
    logic           tx_empty_all;
    logic           trig_hit;
    logic           next_irq;
    byte_t          next_rd;
    logic [3:0]     ident;

    ////////////////////////////////////////////////////////////////////
    // decode; holding and mask hidden while divisor latch is selected
    assign dlab     = line_control[`BIT_DLAB];
    assign wr_hold  = wr_strobe && addr == `ADDR_HOLDING && !dlab;
    assign rd_hold  = rd_strobe && addr == `ADDR_HOLDING && !dlab;
    // fifo off means a single holding slot each way
    assign rx_limit = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
    assign tx_limit = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
    assign tx_take  = !tx_busy && tx_cnt != '0;
    assign rx_push  = rx_done && rx_cnt < rx_limit;
    assign thr_empty    = tx_cnt < tx_limit;
    assign tx_empty_all = tx_cnt == '0 && !tx_busy;
    assign trig_hit     = fifo_en && rx_cnt >= trig_level;

    // trigger levels per select code
    // the fifo fills past the trigger; only the interrupt identity (irq and ident read) uses it
    always_comb begin
        unique case (rx_trig_sel)
            2'b00: trig_level = (AW+1)'(8);
            2'b01: trig_level = (AW+1)'(16);
            2'b10: trig_level = (AW+1)'(24);
            2'b11: trig_level = (AW+1)'(28);
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // control registers
    // line control stays reachable so the lock can be lifted
    always_ff @(posedge clock) begin
        if (srst) begin
            mask         <= `MASK_RESET;
            line_control <= `LCR_RESET;
            fifo_en      <= 1'b0;
            rx_trig_sel  <= 2'b00;
        end else if (wr_strobe) begin
            if (addr == `ADDR_MASK && !dlab)
                mask <= wr_data;
            if (addr == `ADDR_LINE_CONTROL)
                line_control <= wr_data;
            if (addr == `ADDR_IDENT_FIFO) begin
                fifo_en     <= wr_data[`BIT_FIFO_EN];
                rx_trig_sel <= wr_data[7:6];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit fifo; full writes are dropped, host must watch the flag
    // with fifo off the shift register is the second stage
    always_ff @(posedge clock) begin
        if (srst) begin
            tx_wp  <= '0;
            tx_rp  <= '0;
            tx_cnt <= '0;
        end else begin
            if (wr_hold && thr_empty) begin
                tx_mem[tx_wp] <= wr_data;
                tx_wp <= tx_wp + AW'(1);
            end
            if (tx_take)
                tx_rp <= tx_rp + AW'(1);
            tx_cnt <= tx_cnt + (AW+1)'(wr_hold && thr_empty)
                             - (AW+1)'(tx_take);
        end
    end

    // serialiser: start, eight data bits lsb first, stop
    // framing is fixed at 8N1; no parity or long stop
    always_ff @(posedge clock) begin
        if (srst) begin
            tx_busy  <= 1'b0;
            tx_shift <= 8'h00;
            tx_count <= 4'h0;
            tx_bits  <= 4'h0;
            tx_pin   <= 1'b1;
        end else if (tx_take) begin
            tx_busy  <= 1'b1;
            tx_shift <= tx_mem[tx_rp];
            tx_count <= 4'h0;
            tx_bits  <= 4'h0;
            tx_pin   <= 1'b0;
        end else if (tx_busy && tick16) begin
            tx_count <= tx_count + 4'h1;
            if (tx_count == `BIT_SAMPLES) begin
                tx_bits <= tx_bits + 4'h1;
                if (tx_bits == 4'h9) begin
                    tx_busy <= 1'b0;
                end else if (tx_bits == 4'h8) begin
                    tx_pin <= 1'b1;
                end else begin
                    tx_pin   <= tx_shift[0];
                    tx_shift <= {1'b0, tx_shift[7:1]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive front end with false start filter
    uart_rx_front rx_front (
        .clock        (clock),
        .srst         (srst),
        .tick16       (tick16),
        .rx_pin       (rx_pin),
        .rx_byte      (rx_byte),
        .rx_done      (rx_done),
        .rx_frame_err (rx_frame_err),
        .rx_break     (rx_break)
    );

    // receive fifo with per byte error tags; read pops the oldest
    // a byte that finds the fifo full is lost
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_wp     <= '0;
            rx_rp     <= '0;
            rx_cnt    <= '0;
            overrun   <= 1'b0;
            err_total <= '0;
        end else begin
            if (rx_push) begin
                rx_mem[rx_wp]  <= rx_byte;
                err_mem[rx_wp] <= {rx_break, rx_frame_err, 1'b0, overrun};
                rx_wp <= rx_wp + AW'(1);
            end
            // overrun tags the next byte that fits; set beats clear
            if (rx_done && !rx_push)
                overrun <= 1'b1;
            else if (rx_push)
                overrun <= 1'b0;
            if (rd_hold && rx_cnt != '0)
                rx_rp <= rx_rp + AW'(1);
            rx_cnt <= rx_cnt + (AW+1)'(rx_push)
                             - (AW+1)'(rd_hold && rx_cnt != '0);
            err_total <= err_total
                + 6'(rx_push && (rx_frame_err || rx_break || overrun))
                - 6'(rd_hold && rx_cnt != '0 && err_mem[rx_rp] != 4'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // event flags; hardware set wins over a read clear
    // clear-to-send is a pin and is synchronised first
    always_ff @(posedge clock) begin
        if (srst) begin
            cts_sync  <= 3'h0;
            cts_line  <= 1'b0;
            cts_prev  <= 1'b0;
            rts_prev  <= 1'b0;
            cts_flag  <= 1'b0;
            rts_flag  <= 1'b0;
            line_flag <= 1'b0;
        end else begin
            cts_sync <= {cts_sync[1:0], cts_pin};
            if (cts_sync[1] == cts_sync[2])
                cts_line <= cts_sync[2];
            cts_prev <= cts_line;
            rts_prev <= rts_level;
            if (cts_line && !cts_prev)
                cts_flag <= 1'b1;
            else if (rd_strobe && addr == `ADDR_IDENT_FIFO)
                cts_flag <= 1'b0;
            if (rts_level && !rts_prev)
                rts_flag <= 1'b1;
            else if (rd_strobe && addr == `ADDR_IDENT_FIFO)
                rts_flag <= 1'b0;
            if (rx_push)
                line_flag <= 1'b1;
            else if (rd_strobe && addr == `ADDR_LINE_STATUS)
                line_flag <= 1'b0;
        end
    end

    // identity code by priority; trigger code tracks the fill level
    // one read reports only the top pending source
    always_comb begin
        if (mask[2] && line_flag)
            ident = `IDENT_RX_LINE;
        else if (mask[0] && (fifo_en ? trig_hit : rx_cnt != '0))
            ident = `IDENT_RX_DATA;
        else if (mask[1] && thr_empty)
            ident = `IDENT_TX_EMPTY;
        else if (mask[3] && modem_event)
            ident = `IDENT_MODEM;
        else if ((mask[5] && xoff_seen) || (mask[7] && cts_flag)
                 || (mask[6] && rts_flag))
            ident = `IDENT_FLOW;
        else
            ident = `IDENT_NONE;
    end

    // with mask bits 0..3 and 5..7 clear nothing interrupts: polled use
    assign next_irq = ident != `IDENT_NONE;

    ////////////////////////////////////////////////////////////////////
    // read mux
    // reading an empty receive slot leaves pointers alone
    always_comb begin
        next_rd = 8'h00;
        unique case (addr)
            `ADDR_HOLDING:
                if (!dlab)
                    next_rd = rx_mem[rx_rp];
            `ADDR_MASK:
                if (!dlab)
                    next_rd = mask;
            `ADDR_IDENT_FIFO:
                next_rd = {fifo_en, fifo_en, 2'b00, ident};
            `ADDR_LINE_CONTROL:
                next_rd = line_control;
            `ADDR_LINE_STATUS: begin
                next_rd[0]   = rx_cnt != '0;
                next_rd[4:1] = rx_cnt != '0 ? err_mem[rx_rp]
                                            : 4'h0;
                next_rd[5]   = fifo_en ? tx_cnt == '0
                                       : thr_empty;
                next_rd[6]   = tx_empty_all;
                next_rd[7]   = fifo_en && err_total != '0;
            end
            default: next_rd = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // registered outputs
    // all pins leave a flop so decode never glitches them
    always_ff @(posedge clock) begin
        if (srst) begin
            rd_data    <= 8'h00;
            irq        <= 1'b0;
            sleep_mode <= 1'b0;
        end else begin
            if (rd_strobe)
                rd_data <= next_rd;
            irq        <= next_irq;
            sleep_mode <= mask[4];
        end
    end
endmodule : uart_hold

// ==== tb/uart_hold_properties.sv ====
// checker for the uart holding block, bound to its top module
// assumes one clock, synchronous active-high reset, host strobes one wide
module uart_hold_properties
    import uart_hold_pkg::*;
(
    input wire logic                  clock,
    input wire logic                  srst,
    input wire logic [2:0]            addr,
    input wire logic                  wr_strobe,
    input wire logic                  rd_strobe,
    input wire uart_hold_pkg::byte_t  wr_data,
    input wire uart_hold_pkg::byte_t  rd_data,
    input wire logic                  tick16,
    input wire logic                  rx_pin,
    input wire logic                  tx_pin,
    input wire logic                  cts_pin,
    input wire logic                  rts_level,
    input wire logic                  modem_event,
    input wire logic                  xoff_seen,
    input wire logic                  irq,
    input wire logic                  sleep_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mask_sh;
    logic       lcr7;
    logic [5:0] idle_cnt;

    ////////////////////////////////////////////////////////////////////////
    // shadow of the mask; a locked write must not land
    always_ff @(posedge clock) begin
        if (srst) mask_sh <= 8'h00;
        else if (wr_strobe && addr == 3'h1 && !lcr7) mask_sh <= wr_data;
    end
    // divisor latch bit, the lock on holding and mask
    always_ff @(posedge clock) begin
        if (srst) lcr7 <= 1'b0;
        else if (wr_strobe && addr == 3'h3) lcr7 <= wr_data[7];
    end
    // long high line means the transmitter has nothing queued
    always_ff @(posedge clock) begin
        if (srst || !tx_pin) idle_cnt <= 6'h00;
        else if (idle_cnt != 6'h3F) idle_cnt <= idle_cnt + 6'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    a_reset_quiet: assert property (disable iff (1'b0)
        srst |=> !irq && !sleep_mode && tx_pin && rd_data == 8'h00)
        else $error("outputs not quiet after reset");
    a_sleep_follow: assert property (
        (wr_strobe && addr == 3'h1 && !lcr7)
        |=> ##1 sleep_mode == $past(wr_data[4], 2))
        else $error("sleep mode not taken from mask bit 4");
    a_mask_read: assert property (
        (rd_strobe && addr == 3'h1 && !lcr7) |=> rd_data == mask_sh)
        else $error("mask read back wrong");
    a_locked_read: assert property (
        (rd_strobe && addr[2:1] == 2'b00 && lcr7) |=> rd_data == 8'h00)
        else $error("holding or mask visible while locked");
    a_cts_irq: assert property (
        (mask_sh[7] && $rose(cts_pin)) |-> ##[1:8] irq)
        else $error("no interrupt on clear-to-send rise");
    a_rts_irq: assert property (
        (mask_sh[6] && $rose(rts_level)) |-> ##[1:3] irq)
        else $error("no interrupt on request-to-send rise");
    a_xoff_irq: assert property (
        (mask_sh[5] && xoff_seen) |-> ##[1:2] irq)
        else $error("no interrupt on stop character");
    a_modem_irq: assert property (
        (mask_sh[3] && modem_event) |-> ##[1:2] irq)
        else $error("no modem status interrupt");
    a_quiet_irq: assert property (
        (mask_sh == 8'h00 && $past(mask_sh) == 8'h00) |-> !irq)
        else $error("interrupt with every source masked");
    a_tx_start: assert property (
        (wr_strobe && addr == 3'h0 && !lcr7 && idle_cnt == 6'h3F)
        |-> ##[1:6] !tx_pin)
        else $error("written byte did not start a frame");

    c_cts: cover property (mask_sh[7] && $rose(cts_pin));
    c_rx_pop: cover property (rd_strobe && addr == 3'h0 && !lcr7);
    c_rx_irq: cover property (irq && mask_sh[0]);
endmodule : uart_hold_properties

// ==== tb/serial_peer.sv ====
// serial far end: sends frames into the receiver, captures sent frames
// assumes the 16x tick shared with the block, 8 data bits lsb first
module serial_peer (
    input  wire logic  clock,
    input  wire logic  tick16,
    input  wire logic  tx_pin,
    output logic       rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];

    initial rx_pin = 1'b1; // idle line rests at its pull-up level

    ////////////////////////////////////////////////////////////////////////
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clock);
            while (!tick16) @(posedge clock);
        end
    endtask : ticks
    // one frame; a low stop bit makes a framing fault on purpose
    task automatic send_frame(input logic [7:0] b, input logic stop);
        rx_pin <= 1'b0;
        ticks(16);
        for (int i = 0; i < 8; i++) begin
            rx_pin <= b[i];
            ticks(16);
        end
        rx_pin <= stop;
        ticks(16);
        rx_pin <= 1'b1;
        ticks(16);
    endtask : send_frame
    // short low pulse, then idle longer than a whole frame
    task automatic glitch(input int n);
        rx_pin <= 1'b0;
        ticks(n);
        rx_pin <= 1'b1;
        ticks(176);
    endtask : glitch

    ////////////////////////////////////////////////////////////////////////
    // capture: mid-bit sampling from the start edge
    always begin : capture
        logic [7:0] b;
        @(negedge tx_pin);
        ticks(8);
        for (int i = 0; i < 8; i++) begin
            ticks(16);
            b[i] = tx_pin;
        end
        ticks(16);
        got.push_back(b);
    end
endmodule : serial_peer

// ==== tb/uart_hold_bench.sv ====
// bench for the uart holding block: host bus tasks and serial peer
// assumes the design and checker files are compiled before it
module uart_hold_bench
    import uart_hold_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock = 1'b0;
    logic       srst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic       wr_strobe = 1'b0;
    logic       rd_strobe = 1'b0;
    byte_t      wr_data = 8'h00;
    byte_t      rd_data;
    logic       tick16 = 1'b0;
    logic       rx_pin;
    logic       tx_pin;
    logic [3:0] src = 4'h0;
    logic       irq;
    logic       sleep_mode;
    int         fails = 0;
    int         checks = 0;

    always #5 clock = ~clock;
    always @(posedge clock) tick16 <= ~tick16; // 16x tick every 2nd cycle

    uart_hold i_dut (.clock(clock), .srst(srst), .addr(addr),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .wr_data(wr_data),
        .rd_data(rd_data), .tick16(tick16), .rx_pin(rx_pin),
        .tx_pin(tx_pin), .cts_pin(src[0]), .rts_level(src[1]),
        .xoff_seen(src[2]), .modem_event(src[3]), .irq(irq),
        .sleep_mode(sleep_mode));
    serial_peer i_peer (.clock(clock), .tick16(tick16), .tx_pin(tx_pin),
        .rx_pin(rx_pin));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input byte_t seen, exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    task automatic wr(input logic [2:0] a, input byte_t d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output byte_t v);
        @(posedge clock);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
        #1 v = rd_data;
    endtask : rd
    task automatic poll(input byte_t m, input byte_t want);
        byte_t v;
        v = ~want;
        for (int n = 0; n < 500 && (v & m) != want; n++) rd(3'h5, v);
        check("status wait", v & m, want);
    endtask : poll
    task automatic irq_is(input logic want);
        #1 check("irq", {7'h00, irq}, {7'h00, want});
    endtask : irq_is

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        byte_t v;
        rd(3'h1, v);
        check("mask", v, 8'h00);
        rd(3'h5, v);
        check("status", v, 8'h60);
        irq_is(1'b0);
    endtask : t_reset
    // mask write, sleep, and the divisor latch lock
    task automatic t_mask();
        byte_t v;
        wr(3'h1, 8'h10);
        @(posedge clock);
        #1 check("sleep", {7'h00, sleep_mode}, 8'h01);
        wr(3'h3, 8'h80);
        wr(3'h1, 8'h0F);
        rd(3'h1, v);
        check("locked mask", v, 8'h00);
        rd(3'h0, v);
        check("locked hold", v, 8'h00);
        wr(3'h3, 8'h00);
        rd(3'h1, v);
        check("mask kept", v, 8'h10);
        wr(3'h1, 8'h00);
        @(posedge clock);
        #1 check("sleep", {7'h00, sleep_mode}, 8'h00);
    endtask : t_mask
    // two bytes back to back, a third refused while both stages are full
    task automatic t_tx();
        byte_t v;
        wr(3'h1, 8'h02);
        repeat (2) @(posedge clock);
        irq_is(1'b1);
        wr(3'h0, 8'hA5);
        poll(8'h20, 8'h20);
        wr(3'h0, 8'h3C);
        wr(3'h0, 8'hFF);
        rd(3'h5, v);
        check("tx busy", v & 8'h60, 8'h00);
        poll(8'h40, 8'h40);
        @(posedge clock);
        irq_is(1'b1);
        check("tx count", 8'(i_peer.got.size()), 8'h02);
        check("tx first", i_peer.got[0], 8'hA5);
        check("tx second", i_peer.got[1], 8'h3C);
        rd(3'h5, v);
        check("tx done", v, 8'h60);
        wr(3'h1, 8'h00);
    endtask : t_tx
    task automatic t_rx();
        byte_t v;
        wr(3'h1, 8'h04);
        i_peer.send_frame(8'h3C, 1'b1);
        irq_is(1'b1);
        rd(3'h5, v);
        check("rx ready", v, 8'h61);
        rd(3'h0, v);
        check("rx byte", v, 8'h3C);
        rd(3'h5, v);
        check("rx empty", v, 8'h60);
        wr(3'h1, 8'h00);
    endtask : t_rx
    // false start is dropped, the next real frame still lands
    task automatic t_false();
        byte_t v;
        i_peer.glitch(4);
        rd(3'h5, v);
        check("false start", v, 8'h60);
        i_peer.send_frame(8'h5A, 1'b1);
        rd(3'h0, v);
        check("after glitch", v, 8'h5A);
    endtask : t_false
    // trigger of 8, then polled drain and a framing fault
    task automatic t_fifo();
        byte_t v;
        wr(3'h2, 8'h01);
        wr(3'h1, 8'h01);
        for (int i = 0; i < 7; i++) i_peer.send_frame(8'h10 + 8'(i), 1'b1);
        irq_is(1'b0);
        i_peer.send_frame(8'h17, 1'b1);
        irq_is(1'b1);
        rd(3'h2, v);
        check("ident trig", v & 8'h0F, 8'h04);
        rd(3'h0, v);
        check("fifo head", v, 8'h10);
        @(posedge clock);
        irq_is(1'b0);
        rd(3'h2, v);
        check("ident none", v & 8'h0F, 8'h01);
        wr(3'h1, 8'h00);
        for (int i = 1; i < 8; i++) begin
            rd(3'h5, v);
            check("polled ready", v & 8'h01, 8'h01);
            rd(3'h0, v);
            check("fifo order", v, 8'h10 + 8'(i));
        end
        i_peer.send_frame(8'h77, 1'b0);
        rd(3'h5, v);
        check("frame fault", v, 8'hE9);
        rd(3'h0, v);
        check("fault byte", v, 8'h77);
        rd(3'h5, v);
        check("drained", v, 8'h60);
        wr(3'h2, 8'h00);
    endtask : t_fifo
    // clear-to-send, request-to-send, stop character, modem status
    task automatic t_events();
        byte_t m[4] = '{8'h80, 8'h40, 8'h20, 8'h08};
        for (int k = 0; k < 4; k++) begin
            wr(3'h1, m[k]);
            src[k] <= 1'b1;
            repeat (8) @(posedge clock);
            irq_is(1'b1);
            wr(3'h1, 8'h00);
            @(posedge clock);
            irq_is(1'b0);
            @(posedge clock);
            src[k] <= 1'b0;
        end
    endtask : t_events

    ////////////////////////////////////////////////////////////////////////
    initial begin : main
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_mask();
        t_tx();
        t_rx();
        t_false();
        t_fifo();
        t_events();
        summarize();
    end
    // a hang counts as a failure; runs need well under this span
    initial begin : watchdog
        repeat (30000) @(posedge clock);
        fails++;
        summarize();
    end
endmodule : uart_hold_bench

bind uart_hold uart_hold_properties i_props (.clock(clock), .srst(srst),
    .addr(addr), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .wr_data(wr_data), .rd_data(rd_data), .tick16(tick16),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .cts_pin(cts_pin),
    .rts_level(rts_level), .modem_event(modem_event),
    .xoff_seen(xoff_seen), .irq(irq), .sleep_mode(sleep_mode));
